/* File: src/nor_flash_port.sv */
// How it works
// - Sync: latch on strobe rise or clock.
// - Async: latch on strobe rise, else flow.
// - Chip select low activates the die.
// - Chip select high: standby, outputs float.
// - Output enable low gates read drive.
// - Reset clears automation, blocks writes.
// - Reset exit enters async array read.
// - Protect low: lock-down blocks refuse unlock.
// - Protect high: lock-down ignored.
// - Write latch on first rise of write strobe or chip select.
// - Host writes words; device latches them.
// - Drive bus on reads, float when gated.
// - Clock latches the address only in sync; outputs ignore it.
// - Word address LSB is pin A1.
// - Top address pin selects upper die.
// - Multi-chip package: host puts word LSB on A0, unshifted.
// - Host keeps select high when idle.
// - Wait shows invalid data in sync array reads, polarity bit.
`default_nettype none
module nor_flash_port
  import nor_port_pkg::*;
(
  input  wire logic   ref_clk,
  input  wire logic   rst_n,
  nor_bus_if.flash    bus,
  output logic [WORD_ADDR_W-1:0] capturedAddr,
  output logic [DATA_W-1:0]      lastWriteData,
  output logic                   writeSeen,
  output logic                   upperDieSel,
  output logic                   syncMode,
  output logic                   lockedDown,
  output logic                   blockLocked
);
  ////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers for every pin.
  localparam int NSYNC = 6;
  logic [NSYNC-1:0]  pinSync1_r, pinSync2_r, pinPrev_r;
  logic [ADDR_W-1:0] addrSync1_r, addrSync2_r;
  logic [DATA_W-1:0] dataSync1_r, dataSync2_r;
  logic [NSYNC-1:0]  pinRaw;
  assign pinRaw = {bus.linkClk, bus.addressValid_n, bus.chipSelect_n,
                   bus.outputEnable_n, bus.writeStrobe_n, bus.hardwareReset_n};
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinSync1_r  <= '1;
      pinSync2_r  <= '1;
      pinPrev_r   <= '1;
      addrSync1_r <= '0;
      addrSync2_r <= '0;
      dataSync1_r <= '0;
      dataSync2_r <= '0;
    end else begin
      pinSync1_r  <= pinRaw;
      pinSync2_r  <= pinSync1_r;
      pinPrev_r   <= pinSync2_r;
      addrSync1_r <= bus.addr;
      addrSync2_r <= addrSync1_r;
      dataSync1_r <= bus.dataHostOe ? bus.dataHost : '1;
      dataSync2_r <= dataSync1_r;
    end
  end
  logic wpSync1_r, wpSync2_r;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wpSync1_r <= 1'b0;
      wpSync2_r <= 1'b0;
    end else begin
      wpSync1_r <= bus.writeProtect_n;
      wpSync2_r <= wpSync1_r;
    end
  end
  logic clkS, advS, ceS, oeS, weS, rstS;
  assign {clkS, advS, ceS, oeS, weS, rstS} = pinSync2_r;
  logic clkRise, advRise, ceRise, weRise;
  assign clkRise = clkS & ~pinPrev_r[5];
  assign advRise = advS & ~pinPrev_r[4];
  assign ceRise  = ceS  & ~pinPrev_r[3];
  assign weRise  = weS  & ~pinPrev_r[1];

  ////////////////////////////////////////////////////////////////////////
  // Address, write and mode state.
  logic [WORD_ADDR_W-1:0] addr_r, addr_nxt;
  logic [DATA_W-1:0]      wdata_r, wdata_nxt;
  logic                   wseen_r, wseen_nxt;
  logic                   syncHeld_r, syncHeld_nxt;
  logic                   wrArmed_r, wrArmed_nxt;
  logic [CFG_W-1:0]       cfg_r, cfg_nxt;
  read_mode_t             mode_r, mode_nxt;
  logic                   lockSetup_r, lockSetup_nxt;
  logic                   lockDown_r, lockDown_nxt;
  logic                   locked_r, locked_nxt;
  logic [ACC_W-1:0]       acc_r, acc_nxt;
  logic                   isSync, writeLatch;
  logic [WORD_ADDR_W-1:0] pinWordAddr;

  // Pin A1 is word bit 0; the unused A0 position is dropped.
  assign pinWordAddr = addrSync2_r[ADDR_W-1:1];
  assign isSync      = ~cfg_r[SYNC_BIT];
  assign writeLatch  = wrArmed_r & (weRise | ceRise);

  always_comb begin
    addr_nxt      = addr_r;
    wdata_nxt     = wdata_r;
    wseen_nxt     = 1'b0;
    syncHeld_nxt  = syncHeld_r;
    wrArmed_nxt   = wrArmed_r;
    cfg_nxt       = cfg_r;
    mode_nxt      = mode_r;
    lockSetup_nxt = lockSetup_r;
    lockDown_nxt  = lockDown_r;
    locked_nxt    = locked_r;
    acc_nxt       = acc_r;
    if (!rstS) begin
      // Automation cleared, writes blocked, async array on exit.
      cfg_nxt       = CFG_RESET;
      mode_nxt      = RD_ARRAY;
      lockSetup_nxt = 1'b0;
      wrArmed_nxt   = 1'b0;
      syncHeld_nxt  = 1'b0;
    end else if (!ceS) begin
      if (isSync) begin
        // First of strobe rise or clock edge with strobe low wins.
        if (!advS && !syncHeld_r && clkRise) begin
          addr_nxt     = pinWordAddr;
          syncHeld_nxt = 1'b1;
        end else if (advRise && !syncHeld_r) begin
          addr_nxt = pinWordAddr;
        end
        if (advRise || (advS && pinPrev_r[4]))
          syncHeld_nxt = 1'b0;
      end else begin
        // Flow through while strobe low, hold from its rise; clock unused.
        if (!advS || advRise)
          addr_nxt = pinWordAddr;
      end
      if (!weS) begin
        wrArmed_nxt = 1'b1;
        if (!advS && !isSync)
          addr_nxt = pinWordAddr;
      end
      if (!oeS && weS && acc_r != ACC_W'(ACCESS_CYCLES))
        acc_nxt = acc_r + 1'b1;
      if (oeS || advRise || !advS)
        acc_nxt = '0;
    end else begin
      acc_nxt = '0;
    end
    if (writeLatch && rstS) begin
      wdata_nxt   = dataSync2_r;
      wseen_nxt   = 1'b1;
      wrArmed_nxt = 1'b0;
      if (lockSetup_r) begin
        lockSetup_nxt = 1'b0;
        if (dataSync2_r == CMD_UNLOCK) begin
          // Lock-down only binds while protect is low.
          if (!(lockDown_r && !wpSync2_r))
            locked_nxt = 1'b0;
        end else if (dataSync2_r == CMD_LOCKDOWN) begin
          lockDown_nxt = 1'b1;
          locked_nxt   = 1'b1;
        end else if (dataSync2_r == CMD_CFG_CONFIRM) begin
          cfg_nxt = addr_r[CFG_W-1:0];
        end else begin
          locked_nxt = 1'b1;
        end
      end else begin
        case (dataSync2_r)
          CMD_READ_ARRAY:  mode_nxt = RD_ARRAY;
          CMD_READ_STATUS: mode_nxt = RD_STATUS;
          CMD_READ_CONFIG: mode_nxt = RD_CONFIG;
          CMD_LOCK_SETUP:  lockSetup_nxt = 1'b1;
          default:         mode_nxt = RD_STATUS;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_r      <= '0;
      wdata_r     <= '0;
      wseen_r     <= 1'b0;
      syncHeld_r  <= 1'b0;
      wrArmed_r   <= 1'b0;
      cfg_r       <= CFG_RESET;
      mode_r      <= RD_ARRAY;
      lockSetup_r <= 1'b0;
      lockDown_r  <= 1'b0;
      locked_r    <= 1'b1;
      acc_r       <= '0;
    end else begin
      addr_r      <= addr_nxt;
      wdata_r     <= wdata_nxt;
      wseen_r     <= wseen_nxt;
      syncHeld_r  <= syncHeld_nxt;
      wrArmed_r   <= wrArmed_nxt;
      cfg_r       <= cfg_nxt;
      mode_r      <= mode_nxt;
      lockSetup_r <= lockSetup_nxt;
      lockDown_r  <= lockDown_nxt;
      locked_r    <= locked_nxt;
      acc_r       <= acc_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data and wait.  Array contents are modelled as the address pattern,
  // since storage is outside this port.
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic              drive_r, drive_nxt;
  logic              wait_r, wait_nxt;
  logic              dataValid;
  assign dataValid = (acc_r == ACC_W'(ACCESS_CYCLES));
  always_comb begin
    drive_nxt = rstS & ~ceS & ~oeS & weS;
    case (mode_r)
      RD_ARRAY:  rdata_nxt = addr_r[DATA_W-1:0];
      RD_STATUS: rdata_nxt = STATUS_READY;
      RD_CONFIG: rdata_nxt = cfg_r;
      default:   rdata_nxt = '0;
    endcase
    // Asserted level follows the polarity bit; deasserted outside sync reads.
    if (isSync && mode_r == RD_ARRAY && !dataValid)
      wait_nxt = cfg_r[WAIT_POL_BIT];
    else
      wait_nxt = ~cfg_r[WAIT_POL_BIT];
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= '0;
      drive_r <= 1'b0;
      wait_r  <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      drive_r <= drive_nxt;
      wait_r  <= wait_nxt;
    end
  end
  // Enables are gated by the raw pins too, so the bus floats at once.
  assign bus.dataDev   = rdata_r;
  assign bus.dataDevOe = drive_r & ~bus.chipSelect_n & ~bus.outputEnable_n;
  assign bus.waitOut   = wait_r;
  assign bus.waitOe    = drive_r & ~bus.chipSelect_n & ~bus.outputEnable_n;

  assign capturedAddr  = addr_r;
  assign lastWriteData = wdata_r;
  assign writeSeen     = wseen_r;
  assign upperDieSel   = addr_r[TOP_DIE_BIT];
  assign syncMode      = isSync;
  assign lockedDown    = lockDown_r;
  assign blockLocked   = locked_r;
endmodule : nor_flash_port
`default_nettype wire

/* File: pkg/nor_port_pkg.sv */
`default_nettype none
package nor_port_pkg;
  localparam int DATA_W          = 16;
  localparam int ADDR_W          = 26;
  // Word address bit 0 is pin A1 on the discrete packages.
  localparam int WORD_ADDR_W     = ADDR_W - 1;
  localparam int CFG_W           = 16;
  localparam int WAIT_POL_BIT    = 10;
  localparam int TOP_DIE_BIT     = 24;
  localparam int LINK_DIV        = 4;
  localparam int LINK_DIV_W      = 3;
  localparam int ACCESS_CYCLES   = 3;
  localparam int ACC_W           = 3;
  localparam logic [DATA_W-1:0] CMD_READ_ARRAY  = 16'h00FF;
  localparam logic [DATA_W-1:0] CMD_READ_STATUS = 16'h0070;
  localparam logic [DATA_W-1:0] CMD_LOCK_SETUP  = 16'h0060;
  localparam logic [DATA_W-1:0] CMD_UNLOCK      = 16'h00D0;
  localparam logic [DATA_W-1:0] CMD_LOCKDOWN    = 16'h002F;
  localparam logic [DATA_W-1:0] CMD_CFG_CONFIRM = 16'h0003;
  // Code is arbitrary for this model; it selects reads of the configuration word.
  localparam logic [DATA_W-1:0] CMD_READ_CONFIG = 16'h0099;
  localparam logic [CFG_W-1:0]  CFG_RESET       = 16'hBFCF;
  localparam logic [DATA_W-1:0] STATUS_READY    = 16'h0080;
  typedef enum logic [1:0] {
    RD_ARRAY  = 2'b00,
    RD_STATUS = 2'b01,
    RD_CONFIG = 2'b10
  } read_mode_t;
  typedef enum logic [1:0] {
    H_IDLE   = 2'b00,
    H_ADDR   = 2'b01,
    H_STROBE = 2'b10,
    H_DONE   = 2'b11
  } host_state_t;
  // Sync mode when the config read-mode bit (15) is zero.
  localparam int SYNC_BIT = 15;
endpackage : nor_port_pkg
`default_nettype wire

/* File: pkg/nor_bus_if.sv */
`default_nettype none
interface nor_bus_if;
  import nor_port_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic              addressValid_n;
  logic              chipSelect_n;
  logic              outputEnable_n;
  logic              writeStrobe_n;
  logic              hardwareReset_n;
  logic              writeProtect_n;
  logic              linkClk;
  logic [DATA_W-1:0] dataHost;
  logic              dataHostOe;
  logic [DATA_W-1:0] dataDev;
  logic              dataDevOe;
  logic              waitOut;
  logic              waitOe;
  wire  [DATA_W-1:0] dataBus = dataDevOe ? dataDev : (dataHostOe ? dataHost : 16'hFFFF);
  wire               waitLine = waitOe ? waitOut : 1'b1;
  modport flash (input addr, addressValid_n, chipSelect_n, outputEnable_n, writeStrobe_n,
                 hardwareReset_n, writeProtect_n, linkClk, dataHost, dataHostOe,
                 output dataDev, dataDevOe, waitOut, waitOe);
  modport host  (output addr, addressValid_n, chipSelect_n, outputEnable_n, writeStrobe_n,
                 hardwareReset_n, writeProtect_n, linkClk, dataHost, dataHostOe,
                 input dataDev, dataDevOe, waitOut, waitOe, dataBus);
endinterface : nor_bus_if
`default_nettype wire

/* File: src/nor_host_port.sv */
`default_nettype none
module nor_host_port
  import nor_port_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  nor_bus_if.host                     bus,
  input  wire logic                   reqValid,
  input  wire logic                   reqWrite,
  input  wire logic [WORD_ADDR_W-1:0] reqAddr,
  input  wire logic [DATA_W-1:0]      reqData,
  input  wire logic                   flashReset_n,
  input  wire logic                   protect_n,
  input  wire logic                   mcpPackage,
  output logic                        reqReady,
  output logic                        rspValid,
  output logic [DATA_W-1:0]           rspData
);
  localparam int HOLD_CYCLES = 16;
  localparam int HOLD_W      = 5;
  host_state_t       st_r, st_nxt;
  logic [HOLD_W-1:0] cnt_r, cnt_nxt;
  logic [LINK_DIV_W-1:0] div_r, div_nxt;
  logic              lclk_r, lclk_nxt;
  logic              wr_r, wr_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [DATA_W-1:0] wd_r, wd_nxt, rd_r, rd_nxt;
  logic              rsp_r, rsp_nxt;
  logic [DATA_W-1:0] rdS1_r, rdS2_r;

  // Map a word address to pins: A1 is LSB, or A0 on the multi-chip part.
  function automatic logic [ADDR_W-1:0] pinAddr(input logic [WORD_ADDR_W-1:0] w,
                                                input logic mcp);
    pinAddr = mcp ? {1'b0, w} : {w, 1'b0};
  endfunction

  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    wr_nxt   = wr_r;
    addr_nxt = addr_r;
    wd_nxt   = wd_r;
    rd_nxt   = rd_r;
    rsp_nxt  = 1'b0;
    div_nxt  = div_r + 1'b1;
    lclk_nxt = lclk_r;
    if (div_r == LINK_DIV_W'(LINK_DIV - 1)) begin
      div_nxt  = '0;
      lclk_nxt = ~lclk_r;
    end
    case (st_r)
      H_IDLE: if (reqValid) begin
        st_nxt   = H_ADDR;
        wr_nxt   = reqWrite;
        addr_nxt = pinAddr(reqAddr, mcpPackage);
        wd_nxt   = reqData;
        cnt_nxt  = '0;
      end
      H_ADDR: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == HOLD_W'(HOLD_CYCLES / 2 - 1)) begin
          st_nxt  = H_STROBE;
          cnt_nxt = '0;
        end
      end
      H_STROBE: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == HOLD_W'(HOLD_CYCLES - 1)) begin
          st_nxt = H_DONE;
          rd_nxt = rdS2_r;
        end
      end
      H_DONE: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == HOLD_W'(HOLD_CYCLES + HOLD_CYCLES / 2 - 1)) begin
          st_nxt  = H_IDLE;
          rsp_nxt = 1'b1;
        end
      end
      default: st_nxt = H_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r   <= H_IDLE;
      cnt_r  <= '0;
      div_r  <= '0;
      lclk_r <= 1'b0;
      wr_r   <= 1'b0;
      addr_r <= '0;
      wd_r   <= '0;
      rd_r   <= '0;
      rsp_r  <= 1'b0;
      rdS1_r <= '0;
      rdS2_r <= '0;
    end else begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      div_r  <= div_nxt;
      lclk_r <= lclk_nxt;
      wr_r   <= wr_nxt;
      addr_r <= addr_nxt;
      wd_r   <= wd_nxt;
      rd_r   <= rd_nxt;
      rsp_r  <= rsp_nxt;
      rdS1_r <= bus.dataBus;
      rdS2_r <= rdS1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin drive. Select stays high outside an access.
  assign bus.addr            = addr_r;
  assign bus.addressValid_n  = ~(st_r == H_ADDR);
  assign bus.chipSelect_n    = (st_r == H_IDLE);
  assign bus.writeStrobe_n   = ~(wr_r && st_r == H_STROBE);
  assign bus.outputEnable_n  = ~(!wr_r && st_r == H_STROBE);
  assign bus.hardwareReset_n = flashReset_n;
  assign bus.writeProtect_n  = protect_n;
  assign bus.linkClk         = lclk_r;
  assign bus.dataHost        = wd_r;
  assign bus.dataHostOe      = wr_r && st_r != H_IDLE;
  assign reqReady = (st_r == H_IDLE);
  assign rspValid = rsp_r;
  assign rspData  = rd_r;
endmodule : nor_host_port
`default_nettype wire

/* File: verif/nor_port_checker.sv */
`default_nettype none
module nor_port_checker
  import nor_port_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              rst_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic              chipSelect_n,
  input wire logic              outputEnable_n,
  input wire logic              writeStrobe_n,
  input wire logic              hardwareReset_n,
  input wire logic [DATA_W-1:0] dataHost,
  input wire logic              dataHostOe,
  input wire logic              dataDevOe,
  input wire logic              waitOe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // The flash sees its reset pin through two flops, so allow margin before judging.
  sequence rst_held;
    !hardwareReset_n [*4];
  endsequence
  sequence wr_held;
    !writeStrobe_n ##1 !writeStrobe_n;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  cs_float_a: assert property (chipSelect_n |-> !dataDevOe)
    else $error("data driven while deselected");
  oe_float_a: assert property (outputEnable_n |-> !dataDevOe)
    else $error("data driven while output enable is high");
  wait_float_a: assert property ((chipSelect_n || outputEnable_n) |-> !waitOe)
    else $error("wait driven while gated off");
  reset_nodrive_a: assert property (rst_held |-> !dataDevOe)
    else $error("data driven during hardware reset");
  select_idle_a: assert property (chipSelect_n |-> writeStrobe_n && outputEnable_n)
    else $error("strobe active while deselected");
  write_drive_a: assert property (!writeStrobe_n |-> dataHostOe)
    else $error("host not driving data during write");
  write_stable_a: assert property (wr_held |-> $stable(addr) && $stable(dataHost))
    else $error("address or data moved during write strobe");
  no_contention_a: assert property (!(dataHostOe && dataDevOe))
    else $error("both ends drive the data bus");
endmodule : nor_port_checker // nor_port_checker
`default_nettype wire

/* File: verif/tb_top.sv */
`default_nettype none
module tb_top
  import nor_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   ref_clk;
  logic                   rst_n;
  logic                   reqValid;
  logic                   reqWrite;
  logic [WORD_ADDR_W-1:0] reqAddr;
  logic [DATA_W-1:0]      reqData;
  logic                   flashReset_n;
  logic                   protect_n;
  logic                   mcpPackage;
  logic                   reqReady;
  logic                   rspValid;
  logic [DATA_W-1:0]      rspData;
  logic [WORD_ADDR_W-1:0] capturedAddr;
  logic [DATA_W-1:0]      lastWriteData;
  logic                   writeSeen;
  logic                   upperDieSel;
  logic                   syncMode;
  logic                   lockedDown;
  logic                   blockLocked;
  logic                   seen;
  logic                   waitHi;
  logic                   waitLast;
  logic [DATA_W-1:0]      rd;
  logic [ADDR_W-1:0]      busAddr;
  int                     error_cnt;
  int                     cmp_count;

`define CHK(got, exp) begin \
  cmp_count++; \
  if ((got) !== (exp)) begin \
    error_cnt++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); \
  end \
end

  nor_bus_if nor_bus_if_i();
  nor_flash_port nor_flash_port_i (.ref_clk(ref_clk), .rst_n(rst_n), .bus(nor_bus_if_i),
    .capturedAddr(capturedAddr), .lastWriteData(lastWriteData), .writeSeen(writeSeen),
    .upperDieSel(upperDieSel), .syncMode(syncMode), .lockedDown(lockedDown),
    .blockLocked(blockLocked));
  nor_host_port nor_host_port_i (.ref_clk(ref_clk), .rst_n(rst_n), .bus(nor_bus_if_i),
    .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr), .reqData(reqData),
    .flashReset_n(flashReset_n), .protect_n(protect_n), .mcpPackage(mcpPackage),
    .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData));
  nor_port_checker nor_port_checker_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .addr(nor_bus_if_i.addr), .chipSelect_n(nor_bus_if_i.chipSelect_n),
    .outputEnable_n(nor_bus_if_i.outputEnable_n), .writeStrobe_n(nor_bus_if_i.writeStrobe_n),
    .hardwareReset_n(nor_bus_if_i.hardwareReset_n), .dataHost(nor_bus_if_i.dataHost),
    .dataHostOe(nor_bus_if_i.dataHostOe), .dataDevOe(nor_bus_if_i.dataDevOe),
    .waitOe(nor_bus_if_i.waitOe));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // One whole host transfer; the pin address is sampled while the die is selected.
  task automatic acc(input logic w, input logic [WORD_ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d);
    int n;
    @(posedge ref_clk);
    reqValid <= 1'b1;
    reqWrite <= w;
    reqAddr  <= a;
    reqData  <= d;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (reqReady !== 1'b1 && n < 100);
    reqValid <= 1'b0;
    seen = 1'b0;
    waitHi = 1'b0;
    waitLast = 1'b1;
    busAddr = '0;
    n = 0;
    while (rspValid !== 1'b1 && n < 200) begin
      @(posedge ref_clk);
      n++;
      if (writeSeen === 1'b1) seen = 1'b1;
      if (nor_bus_if_i.chipSelect_n === 1'b0) busAddr = nor_bus_if_i.addr;
      if (nor_bus_if_i.waitOe === 1'b1) begin
        if (nor_bus_if_i.waitLine === 1'b1) waitHi = 1'b1;
        waitLast = nor_bus_if_i.waitLine;
      end
    end
    rd = rspData;
    `CHK(n < 200, 1'b1)
    if (mcpPackage === 1'b1) `CHK(busAddr[WORD_ADDR_W-1:0], a)
    else `CHK(busAddr[ADDR_W-1:1], a)
  endtask

  task automatic cmd(input logic [DATA_W-1:0] d);
    acc(1'b1, '0, d);
  endtask

  task automatic pin_reset;
    flashReset_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    flashReset_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    reqValid = 1'b0;
    reqWrite = 1'b0;
    reqAddr = '0;
    reqData = '0;
    flashReset_n = 1'b1;
    protect_n = 1'b1;
    mcpPackage = 1'b0;
    error_cnt = 0;
    cmp_count = 0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    `CHK(syncMode, 1'b0)
    acc(1'b1, 25'h0123456, 16'hA5C3);
    `CHK(seen, 1'b1)
    `CHK(lastWriteData, 16'hA5C3)
    `CHK(capturedAddr, 25'h0123456)
    acc(1'b0, 25'h000ABCD, '0);
    `CHK(rd, STATUS_READY)
    cmd(CMD_READ_ARRAY);
    acc(1'b0, 25'h000ABCD, '0);
    `CHK(rd, 16'hABCD)
    `CHK(waitHi, 1'b0)
    acc(1'b0, 25'h1000011, '0);
    `CHK(upperDieSel, 1'b1)
    `CHK(rd, 16'h0011)
    mcpPackage <= 1'b1;
    acc(1'b0, 25'h0000042, '0);
    mcpPackage <= 1'b0;
    protect_n <= 1'b0;
    cmd(CMD_LOCK_SETUP);
    cmd(CMD_LOCKDOWN);
    `CHK(lockedDown, 1'b1)
    cmd(CMD_LOCK_SETUP);
    cmd(CMD_UNLOCK);
    `CHK(blockLocked, 1'b1)
    protect_n <= 1'b1;
    cmd(CMD_LOCK_SETUP);
    cmd(CMD_UNLOCK);
    `CHK(blockLocked, 1'b0)
    flashReset_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    acc(1'b1, 25'h0000005, 16'h1111);
    `CHK(seen, 1'b0)
    `CHK(lastWriteData, CMD_UNLOCK)
    flashReset_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    cmd(CMD_LOCK_SETUP);
    acc(1'b1, 25'h0003FCF, CMD_CFG_CONFIRM);
    `CHK(syncMode, 1'b1)
    acc(1'b0, 25'h0000055, '0);
    `CHK(rd, 16'h0055)
    `CHK(capturedAddr, 25'h0000055)
    `CHK(waitHi, 1'b1)
    `CHK(waitLast, 1'b0)
    pin_reset();
    `CHK(syncMode, 1'b0)
    acc(1'b0, 25'h0001234, '0);
    `CHK(rd, 16'h1234)
    cmd(CMD_READ_CONFIG);
    acc(1'b0, 25'h0000077, '0);
    `CHK(rd, CFG_RESET)
    summarize();
  end

  initial begin
    repeat (6000) @(posedge ref_clk);
    error_cnt++;
    summarize();
  end
`undef CHK
endmodule : tb_top // tb_top
`default_nettype wire
